//--- hdl/mrx_decode.sv
// Instruction class decoder for bits 14 to 11
`timescale 1ns/10ps
module mrx_decode
(
  input wire logic [15:0] instr,
  output mrx_pkg::mrx_dec_t dec
);

  logic [3:0] opf;

  assign opf = instr[mrx_pkg::OP_HI:mrx_pkg::OP_LO];

  always_comb
  begin
    dec = '0;
    dec.compare_a_op = (opf == mrx_pkg::OP_CMP_A);
    dec.compare_b_op = (opf == mrx_pkg::OP_CMP_B);
    dec.load_a_op = (opf == mrx_pkg::OP_LD_A);
    dec.load_b_op = (opf == mrx_pkg::OP_LD_B);
    dec.store_a_op = (opf == mrx_pkg::OP_ST_A);
    dec.store_b_op = (opf == mrx_pkg::OP_ST_B);
  end

endmodule

//--- hdl/mrx_exec.sv
// Phase-3 execute sequencer for compare, load and store
// Functional notes
// - A load-class word is fetched in phase 1 and its operand work is done in phase 3.
// - Bits 14 to 11 equal to 1010 select compare with A and 1011 compare with B.
// - Compare combines the accumulator and temp word on the T bus in T3-T4 and tests zero.
// - A non-zero compare result sets carry at the end of T4, giving the skip carry in T6T7.
// - A compare ends by loading P and M with P plus one plus carry.
// - Bits 14 to 11 equal to 1100 select load A and 1101 load B.
// - A load reads the memory word into the temp register in T2.
// - A load passes the temp word through S bus and T bus in T3-T4 and strobes A or B.
// - A load overwrites the accumulator while memory is rewritten unchanged.
// - Bits 14 to 11 equal to 1110 select store A and 1111 store B.
// - A store routes A or B via R bus and T bus into the temp register in T1-T2.
// - A store clears the temp register in T0 and inhibits read data in T2.
// - A store writes the temp word to memory in the write half, leaving the accumulator.
// - In T6T7 P goes on the R bus with injected carry and the sum is strobed into P and M.
// - After execute the next phase is 1, or 4 when an interrupt is pending.
// - Instruction loop mode suppresses the carry-in so P and M hold, except that a compare skip carry still adds one.
`timescale 1ns/10ps
module mrx_exec
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic [1:0] phase_in,
  input wire logic [15:0] instr,
  input wire logic [15:0] mem_rdata,
  input wire logic intr_pending,
  input wire logic instr_loop,
  output mrx_pkg::mrx_mem_req_t mem_req,
  output logic [15:0] acc_a,
  output logic [15:0] acc_b,
  output logic [15:0] p_count,
  output logic [15:0] m_addr,
  output logic [15:0] temp_word_reg,
  output logic skip_carry,
  output logic [1:0] next_phase,
  output logic phase_done,
  output logic [2:0] time_period
);

  ////////////////////////////////////////////////////////////////////
  // Decode and timing
  mrx_pkg::mrx_dec_t dec;
  mrx_pkg::mrx_tp_t tp;
  logic cycle_end;

  mrx_decode u_dec
  (
    .instr(instr),
    .dec(dec)
  );

  mrx_timer u_tmr
  (
    .clk(clk),
    .rstn(rstn),
    .tp(tp),
    .cycle_end(cycle_end)
  );

  ////////////////////////////////////////////////////////////////////
  // Bus steering
  logic execute_phase;
  logic cmp_op;
  logic ld_op;
  logic st_op;
  logic use_b;
  logic t_to_s_bus;
  logic a_to_r_bus;
  logic b_to_r_bus;
  logic p_to_r_bus;
  logic load_select;
  logic adder_function;
  logic xor_function;
  logic bus_write_a;
  logic bus_write_b;
  logic bus_write_temp;
  logic carry_in_inject;
  logic p_counter_strobe;
  logic m_addr_strobe;
  logic carry_ff;
  logic [15:0] temp_ff;
  logic [15:0] a_ff;
  logic [15:0] b_ff;
  logic [15:0] p_ff;
  logic [15:0] m_ff;
  logic [15:0] r_bus;
  logic [15:0] s_bus;
  logic [15:0] t_bus;
  logic [15:0] sum;
  logic mid;
  logic early;
  logic late;
  logic mr_op;

  ////////////////////////////////////////////////////////////////////
  // Helpers

  // Inclusive window test on the period counter
  function automatic logic in_span
  (
    input mrx_pkg::mrx_tp_t cur,
    input mrx_pkg::mrx_tp_t lo,
    input mrx_pkg::mrx_tp_t hi
  );
    return (cur >= lo) && (cur <= hi);
  endfunction

  // Single-period strobe test
  function automatic logic at_period
  (
    input mrx_pkg::mrx_tp_t cur,
    input mrx_pkg::mrx_tp_t want
  );
    return cur == want;
  endfunction

  // One-bit term widened for the 16-bit adder
  function automatic logic [15:0] bit_word
  (
    input logic b
  );
    return {15'h0, b};
  endfunction

  ////////////////////////////////////////////////////////////////////
  // Phase and class qualifiers

  // Only phase 3 runs operand work; phase 1 fetch lives elsewhere
  assign execute_phase = (phase_in == mrx_pkg::PH_EXECUTE);
  assign cmp_op = execute_phase && (dec.compare_a_op || dec.compare_b_op);
  assign ld_op = execute_phase && (dec.load_a_op || dec.load_b_op);
  assign st_op = execute_phase && (dec.store_a_op || dec.store_b_op);
  // Other opcodes in phase 3 belong to other blocks and must leave memory alone
  assign mr_op = cmp_op || ld_op || st_op;
  assign use_b = instr[mrx_pkg::OP_LO];
  assign early = in_span(tp, mrx_pkg::TP_T1, mrx_pkg::TP_T2);
  assign mid = in_span(tp, mrx_pkg::TP_T3, mrx_pkg::TP_T4);
  assign late = in_span(tp, mrx_pkg::TP_T6, mrx_pkg::TP_T7);

  always_comb
  begin
    t_to_s_bus = (cmp_op || ld_op) && mid;
    a_to_r_bus = ((cmp_op && mid) || (st_op && early)) && !use_b;
    b_to_r_bus = ((cmp_op && mid) || (st_op && early)) && use_b;
    load_select = ld_op && mid;
    xor_function = cmp_op && mid;
    p_to_r_bus = mr_op && late;
    adder_function = p_to_r_bus;
    carry_in_inject = p_to_r_bus && !instr_loop;
    bus_write_a = load_select && !use_b && at_period(tp, mrx_pkg::TP_T4);
    bus_write_b = load_select && use_b && at_period(tp, mrx_pkg::TP_T4);
    bus_write_temp = st_op && at_period(tp, mrx_pkg::TP_T2);
    p_counter_strobe = p_to_r_bus && at_period(tp, mrx_pkg::TP_T7);
    m_addr_strobe = p_counter_strobe;
  end

  ////////////////////////////////////////////////////////////////////
  // Data path

  always_comb
  begin
    r_bus = 16'h0000;
    if (a_to_r_bus)
    begin
      r_bus = a_ff;
    end
    else if (b_to_r_bus)
    begin
      r_bus = b_ff;
    end
    else if (p_to_r_bus)
    begin
      r_bus = p_ff;
    end
    s_bus = t_to_s_bus ? temp_ff : 16'h0000;
    // Carry out of bit 15 is dropped: P wraps like the hardware counter
    sum = r_bus + s_bus + bit_word(carry_in_inject) + bit_word(skip_carry);
    if (xor_function)
    begin
      t_bus = r_bus ^ s_bus;
    end
    else if (adder_function)
    begin
      t_bus = sum;
    end
    else
    begin
      t_bus = r_bus | s_bus; // Pass-through for load and store
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Register state
  logic [15:0] nxt_temp;
  logic [15:0] nxt_a;
  logic [15:0] nxt_b;
  logic [15:0] nxt_p;
  logic [15:0] nxt_m;
  logic nxt_carry;
  logic [1:0] nxt_phase;
  logic [1:0] phase_ff;

  always_comb
  begin
    nxt_temp = temp_ff;
    nxt_a = a_ff;
    nxt_b = b_ff;
    nxt_p = p_ff;
    nxt_m = m_ff;
    nxt_carry = carry_ff;
    nxt_phase = phase_ff;
    if (mr_op && at_period(tp, mrx_pkg::TP_T0))
    begin
      nxt_temp = mrx_pkg::WORD_RST;
    end
    if ((cmp_op || ld_op) && at_period(tp, mrx_pkg::TP_T2))
    begin
      nxt_temp = mem_rdata;
    end
    // Store ignores read data, so the old word is lost
    if (bus_write_temp)
    begin
      nxt_temp = t_bus;
    end

    if (bus_write_a)
    begin
      nxt_a = t_bus;
    end
    if (bus_write_b)
    begin
      nxt_b = t_bus;
    end

    // Carry lives for one machine cycle so a stale skip cannot leak forward
    if (at_period(tp, mrx_pkg::TP_T0))
    begin
      nxt_carry = 1'b0;
    end
    if (xor_function && at_period(tp, mrx_pkg::TP_T4) && (t_bus != 16'h0000))
    begin
      nxt_carry = 1'b1;
    end

    if (p_counter_strobe)
    begin
      nxt_p = t_bus;
    end
    if (m_addr_strobe)
    begin
      nxt_m = t_bus;
    end
    // Indirect phase is settled upstream, so only fetch or interrupt follows
    if (execute_phase && cycle_end)
    begin
      nxt_phase = intr_pending ? mrx_pkg::PH_INTERRUPT : mrx_pkg::PH_FETCH;
    end
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      temp_ff <= mrx_pkg::WORD_RST;
      a_ff <= mrx_pkg::WORD_RST;
      b_ff <= mrx_pkg::WORD_RST;
      p_ff <= mrx_pkg::WORD_RST;
      m_ff <= mrx_pkg::WORD_RST;
      carry_ff <= 1'b0;
      phase_ff <= mrx_pkg::PH_FETCH;
    end
    else
    begin
      temp_ff <= nxt_temp;
      a_ff <= nxt_a;
      b_ff <= nxt_b;
      p_ff <= nxt_p;
      m_ff <= nxt_m;
      carry_ff <= nxt_carry;
      phase_ff <= nxt_phase;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Memory port: read in T0-T3, rewrite of temp word in T4-T7
  always_comb
  begin
    mem_req.addr = m_ff;
    mem_req.wdata = temp_ff;
    mem_req.read_strobe = (cmp_op || ld_op) && at_period(tp, mrx_pkg::TP_T2);
    // Refused opcodes get no write, so their word is never disturbed
    mem_req.write_strobe = mr_op && at_period(tp, mrx_pkg::TP_T5);
  end

  assign acc_a = a_ff;
  assign acc_b = b_ff;
  assign p_count = p_ff;
  assign m_addr = m_ff;
  assign temp_word_reg = temp_ff;
  assign skip_carry = carry_ff && cmp_op && p_to_r_bus;
  assign next_phase = phase_ff;
  assign phase_done = execute_phase && cycle_end;
  assign time_period = tp;

endmodule

//--- hdl/mrx_pkg.sv
// Package for the memory-reference execute sequencer
package mrx_pkg;

  localparam int unsigned WORD_W = 16;
  localparam logic [3:0] OP_CMP_A = 4'ha;
  localparam logic [3:0] OP_CMP_B = 4'hb;
  localparam logic [3:0] OP_LD_A = 4'hc;
  localparam logic [3:0] OP_LD_B = 4'hd;
  localparam logic [3:0] OP_ST_A = 4'he;
  localparam logic [3:0] OP_ST_B = 4'hf;
  localparam int unsigned OP_HI = 14;
  localparam int unsigned OP_LO = 11;
  localparam logic [2:0] TP_LAST = 3'h7;
  localparam logic [15:0] WORD_RST = 16'h0000;

  typedef enum logic [2:0]
  {
    TP_T0 = 3'b000,
    TP_T1 = 3'b001,
    TP_T2 = 3'b010,
    TP_T3 = 3'b011,
    TP_T4 = 3'b100,
    TP_T5 = 3'b101,
    TP_T6 = 3'b110,
    TP_T7 = 3'b111
  } mrx_tp_t;

  typedef enum logic [1:0]
  {
    PH_FETCH = 2'b00,
    PH_INDIRECT = 2'b01,
    PH_EXECUTE = 2'b10,
    PH_INTERRUPT = 2'b11
  } mrx_phase_t;

  // Memory cycle carrier: address, write data, strobes
  typedef struct packed
  {
    logic [15:0] addr;
    logic [15:0] wdata;
    logic read_strobe;
    logic write_strobe;
  } mrx_mem_req_t;

  // Decoded instruction class
  typedef struct packed
  {
    logic compare_a_op;
    logic compare_b_op;
    logic load_a_op;
    logic load_b_op;
    logic store_a_op;
    logic store_b_op;
  } mrx_dec_t;

endpackage

//--- hdl/mrx_timer.sv
// Time-period generator T0 to T7
`timescale 1ns/10ps
module mrx_timer
(
  input wire logic clk,
  input wire logic rstn,
  output mrx_pkg::mrx_tp_t tp,
  output logic cycle_end
);

  mrx_pkg::mrx_tp_t tp_ff;
  mrx_pkg::mrx_tp_t nxt_tp;

  always_comb
  begin
    nxt_tp = mrx_pkg::mrx_tp_t'(tp_ff + 3'h1);
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      tp_ff <= mrx_pkg::TP_T0;
    else
      tp_ff <= nxt_tp;
  end

  assign tp = tp_ff;
  assign cycle_end = (tp_ff == mrx_pkg::TP_LAST);

endmodule

//--- test/mem_ref_compare_load_store_exec_tb.sv
// Self-checking bench for the memory-reference execute sequencer
`timescale 1ns/10ps
module mem_ref_compare_load_store_exec_tb;
  logic clk, rstn, intr_pending, instr_loop, skip_carry, phase_done;
  logic [1:0] phase_in, next_phase, enp;
  logic [2:0] time_period;
  logic [15:0] instr, mem_rdata, acc_a, acc_b, p_count, m_addr, temp_word_reg, ea, eb, ep;
  logic [15:0] sh_mem [16];
  mrx_pkg::mrx_mem_req_t mem_req;
  int n_fail, tests_run;
  mrx_exec dut_u (.*);
  mrx_core_mem mem_u (.clk(clk), .mem_req(mem_req), .mem_rdata(mem_rdata));
  ////////////////////////////////////////////////////////////////
  function automatic logic [15:0] next_pc(input logic [15:0] p, input logic cy, input logic lp);
    return p + {15'h0, !lp} + {15'h0, cy};
  endfunction
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    tests_run++;
    if (got !== exp)
    begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic results();
    $display("Checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // Entered at the edge that starts T0; final state is checked one cycle later
  task automatic run_cycle(input logic [1:0] ph, input logic [3:0] op, input logic intr,
    input logic lp);
    logic [15:0] w, acc;
    logic ex, st, cy;
    w = sh_mem[ep[3:0]];
    ex = ph == 2'h2 && op >= 4'ha;
    st = op[3:1] == 3'h7;
    acc = op[0] ? eb : ea;
    cy = ex && op[3:1] == 3'h5 && (acc ^ w) != 16'h0;
    phase_in <= ph;
    instr <= {1'($urandom), op, 11'($urandom)};
    intr_pending <= intr;
    instr_loop <= lp;
    @(posedge clk);
    #1;
    chk("acc_a", ea, acc_a);
    chk("acc_b", eb, acc_b);
    chk("p_count", ep, p_count);
    chk("m_addr", ep, m_addr);
    chk("next_phase", {14'h0, enp}, {14'h0, next_phase});
    if (ex)
      chk("temp clear", 16'h0000, temp_word_reg);
    @(posedge clk);
    #1;
    chk("read_strobe", {15'h0, ex && !st}, {15'h0, mem_req.read_strobe});
    @(posedge clk);
    #1;
    if (ex)
      chk("temp word", st ? acc : w, temp_word_reg);
    repeat (4) @(posedge clk);
    #1;
    chk("phase_done", {15'h0, ph == 2'h2}, {15'h0, phase_done});
    chk("skip_carry", {15'h0, cy}, {15'h0, skip_carry});
    if (ex)
    begin
      if (op[3:1] == 3'h6 && op[0])
        eb = w;
      else if (op[3:1] == 3'h6)
        ea = w;
      if (st)
        sh_mem[ep[3:0]] = acc;
      chk("memory", sh_mem[ep[3:0]], mem_u.mem[ep[3:0]]);
      ep = next_pc(ep, cy, lp);
      enp = intr ? 2'h3 : 2'h0;
    end
    @(posedge clk);
  endtask
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  initial
  begin
    #200000;
    n_fail++;
    results();
  end
  initial
  begin
    static logic [3:0] c_op [6] = '{4'hc, 4'he, 4'ha, 4'hb, 4'hd, 4'hf};
    static logic c_in [6] = '{1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1};
    static logic c_lp [6] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0};
    logic [3:0] op;
    logic lp;
    void'($urandom(32'h93c73908));
    {rstn, phase_in, instr, intr_pending, instr_loop} = '0;
    {ea, eb, ep, enp, n_fail, tests_run} = '0;
    foreach (sh_mem[i])
      sh_mem[i] = 16'($urandom);
    sh_mem[2] = sh_mem[0];
    sh_mem[3] = 16'h7fff;
    foreach (sh_mem[i])
      mem_u.mem[i] = sh_mem[i];
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    foreach (c_op[i])
      run_cycle(2'h2, c_op[i], c_in[i], c_lp[i]);
    repeat (40)
    begin
      op = 4'ha + 4'($urandom_range(5));
      lp = op[3:1] != 3'h5 && $urandom_range(3) == 0;
      run_cycle(($urandom_range(3) == 0) ? 2'h0 : 2'h2, op, 1'($urandom), lp);
    end
    run_cycle(2'h0, 4'hc, 1'b0, 1'b0);
    results();
  end
endmodule

//--- test/mrx_core_mem.sv
// Core memory model with read then rewrite in each machine cycle
`timescale 1ns/10ps
module mrx_core_mem
(
  input wire logic clk,
  input mrx_pkg::mrx_mem_req_t mem_req,
  output logic [15:0] mem_rdata
);
  logic [15:0] mem [16];
  logic [15:0] last_q = 16'h5a5a;
  // Sense lines are not held once released, so an idle bus shows the inverse word
  assign mem_rdata = mem_req.read_strobe ? mem[mem_req.addr[3:0]] : ~last_q;
  always @(posedge clk)
  begin
    if (mem_req.read_strobe)
      last_q <= mem[mem_req.addr[3:0]];
    if (mem_req.write_strobe)
      mem[mem_req.addr[3:0]] <= mem_req.wdata;
  end
endmodule

//--- test/mrx_exec_sva.sv
// Port assertions for the execute sequencer
`timescale 1ns/10ps
module mrx_exec_sva
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic [1:0] phase_in,
  input wire logic [15:0] instr,
  input wire logic intr_pending,
  input wire logic instr_loop,
  input mrx_pkg::mrx_mem_req_t mem_req,
  input wire logic [15:0] acc_a,
  input wire logic [15:0] p_count,
  input wire logic [15:0] temp_word_reg,
  input wire logic skip_carry,
  input wire logic [1:0] next_phase,
  input wire logic phase_done,
  input wire logic [2:0] time_period
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (!rstn);
  logic ex;
  assign ex = phase_in == 2'h2 && instr[14:11] >= 4'ha;
  sequence s_start(op);
    time_period == 3'h0 && ex && instr[14:11] == op;
  endsequence
  sequence s_end;
    time_period == 3'h7 && ex;
  endsequence
  property p_tp_step;
    $past(rstn) |-> time_period == $past(time_period) + 3'h1;
  endproperty
  property p_rd_slot;
    mem_req.read_strobe |-> time_period == 3'h2 && ex && instr[14:12] != 3'h7;
  endproperty
  property p_wr_slot;
    mem_req.write_strobe |-> time_period == 3'h5 && phase_in == 2'h2;
  endproperty
  property p_done;
    phase_done == (time_period == 3'h7 && phase_in == 2'h2);
  endproperty
  property p_next_ph;
    s_end |=> next_phase == ($past(intr_pending) ? 2'h3 : 2'h0);
  endproperty
  property p_load_a;
    s_start(4'hc) ##4 1'b1 |=> acc_a == $past(temp_word_reg);
  endproperty
  property p_clear;
    time_period == 3'h0 && ex |=> temp_word_reg == 16'h0000;
  endproperty
  property p_store_keep;
    s_start(4'he) |=> $stable(acc_a) [*7];
  endproperty
  property p_cmp_carry;
    s_start(4'ha) ##4 (acc_a != temp_word_reg) |-> ##2 skip_carry [*2];
  endproperty
  property p_pc;
    s_end |=> p_count == $past(p_count) + 16'(!$past(instr_loop)) + 16'($past(skip_carry));
  endproperty
  a_tp_step: assert property (p_tp_step) else $error("period did not step");
  a_rd_slot: assert property (p_rd_slot) else $error("read strobe misplaced");
  a_wr_slot: assert property (p_wr_slot) else $error("write strobe misplaced");
  a_done: assert property (p_done) else $error("phase done wrong");
  a_next_ph: assert property (p_next_ph) else $error("next phase wrong");
  a_load_a: assert property (p_load_a) else $error("load did not reach A");
  a_clear: assert property (p_clear) else $error("temp not cleared");
  a_store_keep: assert property (p_store_keep) else $error("store changed A");
  a_cmp_carry: assert property (p_cmp_carry) else $error("skip carry missing");
  a_pc: assert property (p_pc) else $error("counter step wrong");
endmodule
bind mrx_exec mrx_exec_sva sva_u (.*);
